// ---- blc_pkg.sv ----
package blc_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses on the 9-bit register port
  // ---------------------------------------------------------------------------
  localparam logic [8:0] ADDR_FILTER_CFG   = 9'h080;
  localparam logic [8:0] ADDR_LEVEL_CTRL   = 9'h081;
  localparam logic [8:0] ADDR_SHORTFALL    = 9'h088;
  localparam logic [8:0] ADDR_ROW_CFG      = 9'h0c5;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int FC_TARGET_LSB = 0;
  localparam int FC_TARGET_MSB = 7;
  localparam int FC_DEPTH_LSB  = 8;
  localparam int FC_DEPTH_MSB  = 10;
  localparam int LC_AUTO_BIT   = 0;
  localparam int LC_OFS_LSB    = 1;
  localparam int LC_OFS_MSB    = 9;
  localparam int LC_NEG_BIT    = 10;
  localparam int RC_ROWS_LSB   = 0;
  localparam int RC_ROWS_MSB   = 7;
  localparam int RC_SKIP_BIT   = 8;

  // ---------------------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FILTER_CFG_RST = 16'h0310;
  localparam logic [15:0] LEVEL_CTRL_RST = 16'h0001;
  localparam logic [15:0] ROW_CFG_RST    = 16'h0108;
  localparam logic [8:0]  OFS_FREEZE     = 9'h1ff;
  localparam logic [8:0]  GS_LINE_KERNELS = 9'h0a2;
  localparam int          KERNEL_COLS    = 8;
  localparam int          KERNEL_SHIFT   = 3;
  localparam int          DEPTH_MAX      = 7;

  typedef enum logic [1:0] {
    ST_IMAGE  = 2'b00,
    ST_BLACK  = 2'b01,
    ST_UPDATE = 2'b10
  } blc_state_t;

endpackage

// ---- blc_pair_buf.sv ----
`timescale 1ns/1ns

module blc_pair_buf #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  // ---------------------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ---- blc_black_cal.sv ----
// Function
// - Each frame starts with the programmed count of black lines, one to 255.
// - Global shutter black lines are 162 kernels long regardless of window.
// - Rolling shutter black lines match the active window line length.
// - Skip bit blanks the first black line and keeps it out of calibration.
// - Auto mode derives offsets from black samples and applies them to image pixels.
// - Manual mode stops calibration and applies the 9-bit manual offset.
// - Black samples leave raw and uncompensated in every mode.
// - Manual offset is added when negate is 0, subtracted when 1.
// - Manual mode uses one identical offset for all data paths.
// - Auto mode with manual field all ones freezes the calculated factors.
// - Any other manual field value resumes factor updates in auto mode.
// - Auto mode recalculates factors once per frame from its black samples.
// - Negate bit is ignored while auto mode is enabled.
// - Calibration runs separately for each of the eight kernel columns per frame.
// - Filter uses two to the power of the 3-bit depth field samples.
// - A per-path error bit flags fewer black samples than requested.
`timescale 1ns/1ns

module blc_black_cal
  import blc_pkg::*;
#(
  parameter int PIX_W = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              frame_start,
  input  wire logic              rolling_shutter,
  input  wire logic [8:0]        active_line_kernels,
  input  wire logic [8:0]        reg_addr,
  input  wire logic              reg_wr_en,
  input  wire logic [15:0]       reg_wr_data,
  output logic      [15:0]       reg_rd_data,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [PIX_W-1:0]  in_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic      [PIX_W-1:0]  out_data,
  output logic                   out_black,
  output logic [KERNEL_COLS-1:0] dark_sample_shortfall
);

  import blc_pkg::*;

  // Offsets carry one bit of sign and one bit of headroom above the pixel
  // width, so that a factor of target minus a full-scale mean still fits.
  localparam int OFS_W = PIX_W + 2;
  // The sum is one bit wider again, so that pixel plus offset never wraps
  // before the saturation test looks at it.
  localparam int SUM_W = PIX_W + 3;
  // The accumulator holds up to two to the power of the largest depth
  // full-scale samples without overflow.
  localparam int ACC_W = PIX_W + DEPTH_MAX;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [PIX_W-1:0] sat_add(input logic [PIX_W-1:0] pix,
                                               input logic [OFS_W-1:0] ofs);
    logic signed [SUM_W-1:0] sum;
    sum = $signed({3'b000, pix}) + $signed({ofs[OFS_W-1], ofs});
    if (sum < 0) begin
      sat_add = '0;
    end else if (sum > $signed({3'b000, {PIX_W{1'b1}}})) begin
      sat_add = {PIX_W{1'b1}};
    end else begin
      sat_add = sum[PIX_W-1:0];
    end
  endfunction

  function automatic logic [11:0] kern_to_pix(input logic [8:0] kernels);
    kern_to_pix = {kernels, 3'b000};
  endfunction

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [15:0]            filter_cfg_reg;
  logic [15:0]            level_ctrl_reg;
  logic [15:0]            row_cfg_reg;
  logic [15:0]            reg_rd_data_reg;
  logic [15:0]            reg_rd_data_next;
  logic [KERNEL_COLS-1:0] shortfall_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filter_cfg_reg <= FILTER_CFG_RST;
      level_ctrl_reg <= LEVEL_CTRL_RST;
      row_cfg_reg    <= ROW_CFG_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == ADDR_FILTER_CFG) begin
        filter_cfg_reg <= reg_wr_data;
      end else if (reg_addr == ADDR_LEVEL_CTRL) begin
        level_ctrl_reg <= reg_wr_data;
      end else if (reg_addr == ADDR_ROW_CFG) begin
        row_cfg_reg <= reg_wr_data;
      end
    end
  end

  // Unmapped addresses and reserved bits read as zero.
  // The read port is registered: the word for an address shows one cycle
  // after the address is presented, which keeps the decode off the path to
  // the outside world.
  // The shortfall word is read only; writes to it are dropped above.
  always_comb begin
    reg_rd_data_next = 16'h0000;
    if (reg_addr == ADDR_FILTER_CFG) begin
      reg_rd_data_next = {5'h00, filter_cfg_reg[FC_DEPTH_MSB:0]};
    end else if (reg_addr == ADDR_LEVEL_CTRL) begin
      reg_rd_data_next = {5'h00, level_ctrl_reg[LC_NEG_BIT:0]};
    end else if (reg_addr == ADDR_ROW_CFG) begin
      reg_rd_data_next = {7'h00, row_cfg_reg[RC_SKIP_BIT:0]};
    end else if (reg_addr == ADDR_SHORTFALL) begin
      reg_rd_data_next = {8'h00, shortfall_reg};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rd_data_reg <= 16'h0000;
    end else begin
      reg_rd_data_reg <= reg_rd_data_next;
    end
  end

  assign reg_rd_data           = reg_rd_data_reg;
  assign dark_sample_shortfall = shortfall_reg;

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------
  wire       auto_en   = level_ctrl_reg[LC_AUTO_BIT];
  wire [8:0] man_ofs   = level_ctrl_reg[LC_OFS_MSB:LC_OFS_LSB];
  wire       man_neg   = level_ctrl_reg[LC_NEG_BIT];
  wire [2:0] depth     = filter_cfg_reg[FC_DEPTH_MSB:FC_DEPTH_LSB];
  wire [7:0] target    = filter_cfg_reg[FC_TARGET_MSB:FC_TARGET_LSB];
  wire [7:0] need_cnt  = 8'h01 << depth;
  wire       freeze    = auto_en & (man_ofs == OFS_FREEZE);
  wire [7:0] rows_cfg  = row_cfg_reg[RC_ROWS_MSB:RC_ROWS_LSB];
  // A programmed count of zero is outside the legal range and runs as one line.
  wire [7:0] rows_safe = (rows_cfg == 8'h00) ? 8'h01 : rows_cfg;
  wire [11:0] line_pix = rolling_shutter ? kern_to_pix(active_line_kernels)
                                         : kern_to_pix(GS_LINE_KERNELS);

  // ---------------------------------------------------------------------------
  // Frame sequencing
  // ---------------------------------------------------------------------------
  blc_state_t state_reg;
  blc_state_t state_next;
  logic [7:0]  rows_act_reg;
  logic        skip_act_reg;
  logic [11:0] line_pix_reg;
  logic [11:0] pix_cnt_reg;
  logic [7:0]  line_cnt_reg;
  logic [KERNEL_SHIFT-1:0] col_reg;

  // The sequencer is a simple loop: a frame start always forces the black
  // phase, the last black pixel moves it to a single update cycle, and the
  // image phase then lasts until the next frame start.
  // During the update cycle the input is refused so that no image pixel can
  // be compensated with a factor that is being overwritten.
  // The limitation is one lost input cycle per frame, which the upstream
  // datapath absorbs through its own valid and ready.
  wire buf_in_ready;
  wire in_black  = (state_reg == ST_BLACK);
  // Blanked pixels are consumed without reaching the buffer.
  wire blank_now = in_black & skip_act_reg & (line_cnt_reg == 8'h00);
  assign in_ready = (state_reg != ST_UPDATE) & (buf_in_ready | blank_now);
  wire fire      = in_valid & in_ready;
  wire line_end  = (pix_cnt_reg == line_pix_reg - 12'h001);
  wire last_line = (line_cnt_reg == rows_act_reg - 8'h01);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IMAGE: begin
        state_next = ST_IMAGE;
      end
      ST_BLACK: begin
        if (fire & line_end & last_line) begin
          state_next = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        state_next = ST_IMAGE;
      end
      default: begin
        state_next = ST_IMAGE;
      end
    endcase
    if (frame_start) begin
      state_next = ST_BLACK;
    end
  end

  // Line geometry is captured at frame start so mid-frame writes cannot
  // shorten or stretch the black lines already under way.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg    <= ST_IMAGE;
      rows_act_reg <= 8'h01;
      skip_act_reg <= 1'b0;
      line_pix_reg <= kern_to_pix(GS_LINE_KERNELS);
    end else begin
      state_reg <= state_next;
      if (frame_start) begin
        rows_act_reg <= rows_safe;
        skip_act_reg <= row_cfg_reg[RC_SKIP_BIT];
        line_pix_reg <= line_pix;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset | frame_start) begin
      pix_cnt_reg  <= 12'h000;
      line_cnt_reg <= 8'h00;
      col_reg      <= '0;
    end else if (fire) begin
      col_reg <= col_reg + 1'b1;
      if (in_black) begin
        pix_cnt_reg <= line_end ? 12'h000 : pix_cnt_reg + 12'h001;
        if (line_end) begin
          line_cnt_reg <= line_cnt_reg + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Per-column black filtering
  // ---------------------------------------------------------------------------
  // One accumulator and one sample counter per kernel column. Both are
  // cleared at each frame start, so a frame never mixes its samples with
  // those of the frame before; the factors, by contrast, persist.
  logic [ACC_W-1:0] acc_reg [KERNEL_COLS];
  logic [7:0]       cnt_reg [KERNEL_COLS];
  logic [OFS_W-1:0] factor_reg [KERNEL_COLS];

  wire use_sample = fire & in_black & ~blank_now;
  // Only the first 2^depth samples of a column are averaged, so the sum is an
  // exact power-of-two mean and needs no divider.
  wire take_sample = use_sample & (cnt_reg[col_reg] < need_cnt);

  always_ff @(posedge ref_clk) begin
    if (reset | frame_start) begin
      for (int i = 0; i < KERNEL_COLS; i++) begin
        acc_reg[i] <= '0;
        cnt_reg[i] <= 8'h00;
      end
    end else if (take_sample) begin
      acc_reg[col_reg] <= acc_reg[col_reg] + ACC_W'(in_data);
      cnt_reg[col_reg] <= cnt_reg[col_reg] + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Factor update, once per frame after the last black line
  // ---------------------------------------------------------------------------
  // The new factor is the target level minus the mean of the black samples.
  // A column with too few samples raises its shortfall bit; the shortfall
  // word is refreshed every frame, whatever the calibration mode, so that
  // software can see the problem before it turns automatic mode on.
  logic [OFS_W-1:0] factor_new [KERNEL_COLS];
  logic [KERNEL_COLS-1:0] short_new;

  always_comb begin
    for (int i = 0; i < KERNEL_COLS; i++) begin
      factor_new[i] = OFS_W'({4'h0, target}) - OFS_W'(PIX_W'(acc_reg[i] >> depth));
      short_new[i]  = (cnt_reg[i] < need_cnt);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shortfall_reg <= '0;
      for (int i = 0; i < KERNEL_COLS; i++) begin
        factor_reg[i] <= '0;
      end
    end else if (state_reg == ST_UPDATE) begin
      shortfall_reg <= short_new;
      for (int i = 0; i < KERNEL_COLS; i++) begin
        // A column that fell short keeps its last good factor.
        if (auto_en & ~freeze & ~short_new[i]) begin
          factor_reg[i] <= factor_new[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Compensation of image pixels
  // ---------------------------------------------------------------------------
  // Mode and offset changes take effect at once rather than at a frame
  // boundary; a change in mid-frame can therefore split one image between
  // two offsets, a trade for not holding a second copy of the control word.
  // Black pixels always pass raw, so external statistics stay valid.
  wire [OFS_W-1:0] man_ext   = OFS_W'(man_ofs);
  wire [OFS_W-1:0] man_sign  = man_neg ? (~man_ext + 1'b1) : man_ext;
  wire [OFS_W-1:0] apply_ofs = auto_en ? factor_reg[col_reg]
                                       : man_sign;
  wire [PIX_W-1:0] comp_pix  = sat_add(in_data, apply_ofs);
  wire [PIX_W-1:0] send_pix  = in_black ? in_data : comp_pix;

  // ---------------------------------------------------------------------------
  // Output buffer
  // ---------------------------------------------------------------------------
  // The pair buffer lets the receiver stall for a cycle without the pipeline
  // dropping a word; its ready throttles the input.
  wire [PIX_W:0] buf_out;

  blc_pair_buf #(
    .WIDTH (PIX_W + 1),
    .DEPTH (2)
  ) u_buf (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (fire & ~blank_now),
    .in_ready  (buf_in_ready),
    .in_data   ({in_black, send_pix}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out)
  );

  // The black flag travels with its pixel through the buffer, so the
  // receiver can tell black samples from image pixels even after a stall.
  assign out_black = buf_out[PIX_W];
  assign out_data  = buf_out[PIX_W-1:0];

endmodule

// ---- blc_black_cal_properties.sv ----
`timescale 1ns/1ns

module blc_black_cal_properties
  import blc_pkg::*;
#(
  parameter int PIX_W = 10
) (
  input wire logic                   ref_clk,
  input wire logic                   reset,
  input wire logic                   frame_start,
  input wire logic                   rolling_shutter,
  input wire logic [8:0]             active_line_kernels,
  input wire logic [8:0]             reg_addr,
  input wire logic                   reg_wr_en,
  input wire logic [15:0]            reg_wr_data,
  input wire logic [15:0]            reg_rd_data,
  input wire logic                   in_valid,
  input wire logic                   in_ready,
  input wire logic [PIX_W-1:0]       in_data,
  input wire logic                   out_valid,
  input wire logic                   out_ready,
  input wire logic [PIX_W-1:0]       out_data,
  input wire logic                   out_black,
  input wire logic [KERNEL_COLS-1:0] dark_sample_shortfall
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_row_write;
    reg_wr_en && reg_addr == ADDR_ROW_CFG;
  endsequence
  sequence s_row_revisit;
    s_row_write ##1 reg_addr == ADDR_ROW_CFG;
  endsequence

  property p_reset_state;
    $fell(reset) |-> !out_valid && in_ready && reg_rd_data == 16'h0000 && dark_sample_shortfall == 8'h00;
  endproperty
  property p_hold_output;
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_black);
  endproperty
  property p_push_source;
    $rose(out_valid) |-> $past(in_valid) && $past(in_ready);
  endproperty
  // Shortfall may only move in the update cycle, or when a reset has just cleared it.
  property p_shortfall_update;
    !$stable(dark_sample_shortfall) |-> !$past(in_ready) || $past(reset);
  endproperty
  property p_update_single;
    !in_ready && out_ready |=> in_ready;
  endproperty
  property p_level_reserved;
    reg_addr == ADDR_LEVEL_CTRL |=> reg_rd_data[15:11] == 5'h00;
  endproperty
  property p_filter_reserved;
    reg_addr == ADDR_FILTER_CFG |=> reg_rd_data[15:11] == 5'h00;
  endproperty
  property p_row_readback;
    s_row_revisit |=> reg_rd_data == ($past(reg_wr_data, 2) & 16'h01ff);
  endproperty

  a_reset_state: assert property (p_reset_state) else $error("state after reset is wrong");
  a_hold_output: assert property (p_hold_output) else $error("output changed while stalled");
  a_push_source: assert property (p_push_source) else $error("output without a taken pixel");
  a_shortfall_update: assert property (p_shortfall_update) else $error("shortfall moved off update");
  a_update_single: assert property (p_update_single) else $error("input refused too long");
  a_level_reserved: assert property (p_level_reserved) else $error("level reserved bits set");
  a_filter_reserved: assert property (p_filter_reserved) else $error("filter reserved bits set");
  a_row_readback: assert property (p_row_readback) else $error("row config readback wrong");
endmodule

bind blc_black_cal blc_black_cal_properties #(.PIX_W(PIX_W)) i_props (
  .ref_clk, .reset, .frame_start, .rolling_shutter, .active_line_kernels, .reg_addr, .reg_wr_en,
  .reg_wr_data, .reg_rd_data, .in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_data,
  .out_black, .dark_sample_shortfall
);

// ---- blc_pixel_port.sv ----
`timescale 1ns/1ns

module blc_pixel_port (
  input  wire logic       ref_clk,
  input  wire logic       stall,
  input  wire logic       in_ready,
  output logic            in_valid,
  output logic      [9:0] in_data,
  input  wire logic       out_valid,
  input  wire logic [9:0] out_data,
  input  wire logic       out_black,
  output logic            out_ready
);
  int         n_black = 0;
  int         n_image = 0;
  logic [9:0] last_blk = 10'h000;
  logic [9:0] last_img = 10'h000;
  logic [1:0] phase = 2'h0;

  initial begin
    in_valid  = 1'b0;
    in_data   = 10'h155;
    out_ready = 1'b1;
  end

  // Each pixel is held until an edge samples ready high.
  task automatic send(input int n, input logic [9:0] v);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_data  <= v;
      do @(posedge ref_clk); while (in_ready !== 1'b1);
    end
  endtask

  // A released data bus shows the inverse so a stale value is never taken for real.
  task automatic idle;
    in_valid <= 1'b0;
    in_data  <= ~in_data;
  endtask

  always @(posedge ref_clk) begin
    phase     <= phase + 2'h1;
    out_ready <= !stall || phase == 2'h3;
    if (out_valid && out_ready) begin
      if (out_black) begin
        n_black  <= n_black + 1;
        last_blk <= out_data;
      end else begin
        n_image  <= n_image + 1;
        last_img <= out_data;
      end
    end
  end
endmodule

// ---- blc_black_cal_test.sv ----
`timescale 1ns/1ns

module blc_black_cal_test;
  import blc_pkg::*;

  logic                   ref_clk = 1'b0;
  logic                   reset = 1'b1;
  logic                   frame_start = 1'b0;
  logic                   rolling_shutter = 1'b1;
  logic [8:0]             active_line_kernels = 9'h008;
  logic [8:0]             reg_addr = 9'h000;
  logic                   reg_wr_en = 1'b0;
  logic [15:0]            reg_wr_data = 16'h0000;
  logic [15:0]            reg_rd_data;
  logic                   in_valid;
  logic                   in_ready;
  logic [9:0]             in_data;
  logic                   out_valid;
  logic                   out_ready;
  logic [9:0]             out_data;
  logic                   out_black;
  logic [KERNEL_COLS-1:0] dark_sample_shortfall;
  logic                   stall = 1'b0;
  int                     num_errors = 0;
  int                     n_compared = 0;
  int                     cycles = 0;

  always #2 ref_clk = ~ref_clk;

  blc_black_cal #(.PIX_W(10)) i_dut (
    .ref_clk, .reset, .frame_start, .rolling_shutter, .active_line_kernels, .reg_addr, .reg_wr_en,
    .reg_wr_data, .reg_rd_data, .in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_data,
    .out_black, .dark_sample_shortfall
  );

  blc_pixel_port i_port (
    .ref_clk, .stall, .in_ready, .in_valid, .in_data, .out_valid, .out_data, .out_black, .out_ready
  );

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr    <= a;
    reg_wr_en   <= 1'b1;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1 check(reg_rd_data, exp);
  endtask

  // A frame is a blanked-candidate first line, the remaining black lines, then 16 image pixels.
  task automatic frame(input int n1, input logic [9:0] v1, input int n2, input logic [9:0] v2,
                       input logic [9:0] vi, input int eb, input logic [9:0] ei);
    @(posedge ref_clk);
    frame_start <= 1'b1;
    i_port.n_black = 0;
    i_port.n_image = 0;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    i_port.send(n1, v1);
    i_port.send(n2, v2);
    i_port.send(16, vi);
    i_port.idle();
    for (int i = 0; i < 400 && i_port.n_image < 16; i++) @(posedge ref_clk);
    check(i_port.n_black[15:0], eb[15:0]);
    check({6'h00, i_port.last_blk}, {6'h00, v2});
    check({6'h00, i_port.last_img}, {6'h00, ei});
  endtask

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done;
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADDR_LEVEL_CTRL, LEVEL_CTRL_RST);
    rd(ADDR_ROW_CFG, ROW_CFG_RST);
    rd(ADDR_FILTER_CFG, FILTER_CFG_RST);
    wr(ADDR_SHORTFALL, 16'h00ff);
    rd(ADDR_SHORTFALL, 16'h0000);
    rd(9'h1f0, 16'h0000);
    wr(ADDR_ROW_CFG, 16'hfe03);
    rd(ADDR_ROW_CFG, 16'h0003);
    wr(ADDR_ROW_CFG, 16'h0103);
    stall <= 1'b1;
    frame(64, 10'h3ff, 128, 10'h030, 10'h100, 128, 10'h0e0);
    stall <= 1'b0;
    wr(ADDR_LEVEL_CTRL, 16'h0401);
    frame(64, 10'h3ff, 128, 10'h008, 10'h100, 128, 10'h108);
    wr(ADDR_LEVEL_CTRL, 16'h03ff);
    frame(64, 10'h3ff, 128, 10'h040, 10'h100, 128, 10'h108);
    wr(ADDR_LEVEL_CTRL, 16'h0003);
    frame(64, 10'h3ff, 128, 10'h040, 10'h010, 128, 10'h000);
    wr(ADDR_LEVEL_CTRL, 16'h0020);
    frame(64, 10'h3ff, 128, 10'h200, 10'h3f8, 128, 10'h3ff);
    wr(ADDR_LEVEL_CTRL, 16'h0420);
    wr(ADDR_ROW_CFG, 16'h0001);
    rolling_shutter <= 1'b0;
    frame(0, 10'h000, 1296, 10'h155, 10'h100, 1296, 10'h0f0);
    rolling_shutter <= 1'b1;
    wr(ADDR_FILTER_CFG, 16'hff10);
    rd(ADDR_FILTER_CFG, 16'h0710);
    wr(ADDR_ROW_CFG, 16'h0102);
    frame(64, 10'h3ff, 64, 10'h020, 10'h100, 64, 10'h0f0);
    check({8'h00, dark_sample_shortfall}, 16'h00ff);
    rd(ADDR_SHORTFALL, 16'h00ff);
    test_done;
  end
endmodule
